// ---- common/bst_pkg.sv ----
// boundary-scan test port: shared constants, states and carriers
package bst_pkg;

    // tap controller states, four bits, gray steps along the common path
    typedef enum logic [3:0] {
        BST_TLR    = 4'h0,
        BST_RTI    = 4'h1,
        BST_SELDR  = 4'h3,
        BST_CAPDR  = 4'h2,
        BST_SHDR   = 4'h6,
        BST_EX1DR  = 4'h7,
        BST_PSDR   = 4'h5,
        BST_EX2DR  = 4'h4,
        BST_UPDDR  = 4'hC,
        BST_SELIR  = 4'hD,
        BST_CAPIR  = 4'hF,
        BST_SHIR   = 4'hE,
        BST_EX1IR  = 4'hA,
        BST_PSIR   = 4'hB,
        BST_EX2IR  = 4'h9,
        BST_UPDIR  = 4'h8
    } bst_state_e;

    // instruction register
    localparam int          BST_IR_W        = 3;
    localparam logic [2:0]  BST_OP_EXTEST   = 3'h0;
    localparam logic [2:0]  BST_OP_SAMPLE   = 3'h1;
    localparam logic [2:0]  BST_OP_IDCODE   = 3'h2;
    localparam logic [2:0]  BST_OP_BYPASS   = 3'h7;
    localparam logic [2:0]  BST_IR_CAPTURE  = 3'h1;

    // identification register fields
    localparam int          BST_ID_W        = 32;
    localparam logic [3:0]  BST_ID_VERSION  = 4'h1;    // arbitrary value
    localparam logic [15:0] BST_ID_PART     = 16'h0A5C; // arbitrary value
    localparam logic [10:0] BST_ID_NUMBER   = 11'h155;  // arbitrary value
    localparam logic        BST_ID_LSB      = 1'h1;

    // boundary register: one data and one enable cell per user pin
    localparam int          BST_IO_N        = 8;
    localparam int          BST_BSR_W       = 2 * BST_IO_N;

    // strap settle time in clocks after internal reset release
    localparam logic [1:0]  BST_STRAP_WAIT  = 2'h2;

    // test port pins as seen from outside
    typedef struct packed {
        logic reserve;
        logic tck;
        logic tms;
        logic tdi;
    } bst_pins_s;

endpackage : bst_pkg

// ---- core/bst_tap.sv ----
// boundary-scan tap controller with bypass, id and boundary registers
`timescale 1ns/1ps
module bst_tap
    import bst_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire bst_pins_s           pins,
    input  wire logic [BST_IO_N-1:0] pad_in,
    input  wire logic [BST_IO_N-1:0] core_out,
    input  wire logic [BST_IO_N-1:0] core_oe,
    output logic                     tdo_o,
    output logic                     tdo_oe,
    output logic [BST_IO_N-1:0]      pad_out,
    output logic [BST_IO_N-1:0]      pad_oe,
    output logic [BST_IO_N-1:0]      core_in,
    output logic                     user_mode
);

    // reset release through two flops
    logic rst_meta_ff;
    logic rst_sync_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire rst_n = rst_sync_ff;

    // pin synchronisers; tms resets high like an idle pulled-up pin
    localparam bst_pins_s PINS_RST = '{reserve: 1'b0, tck: 1'b0, tms: 1'b1, tdi: 1'b0};
    bst_pins_s             pin_meta_ff;
    bst_pins_s             pin_sync_ff;
    logic                  tck_dly_ff;
    logic [BST_IO_N-1:0]   pad_meta_ff;
    logic [BST_IO_N-1:0]   pad_sync_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= PINS_RST;
            pin_sync_ff <= PINS_RST;
            tck_dly_ff  <= 1'b0;
            pad_meta_ff <= '0;
            pad_sync_ff <= '0;
        end else begin
            pin_meta_ff <= pins;
            pin_sync_ff <= pin_meta_ff;
            tck_dly_ff  <= pin_sync_ff.tck;
            pad_meta_ff <= pad_in;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    // tck edges found on the system clock; tck must stay well below clk/4
    wire tck_rise = pin_sync_ff.tck & ~tck_dly_ff;
    wire tck_fall = ~pin_sync_ff.tck & tck_dly_ff;
    wire tms_s    = pin_sync_ff.tms;
    wire tdi_s    = pin_sync_ff.tdi;

    // reserve strap caught once the synchroniser has settled;
    // the first two samples see the synchroniser's reset value, only the last of the three sees the pin
    logic [1:0] strap_cnt_ff;
    logic       reserved_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_ff <= '0;
            reserved_ff  <= 1'b0;
        end else if (strap_cnt_ff <= BST_STRAP_WAIT) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            reserved_ff  <= pin_sync_ff.reserve;
        end
    end

    // next-state table of the sixteen-state diagram
    bst_state_e state_ff;
    bst_state_e nxt_state;
    always_comb begin
        case (state_ff)
            BST_TLR:   nxt_state = tms_s ? BST_TLR   : BST_RTI;
            BST_RTI:   nxt_state = tms_s ? BST_SELDR : BST_RTI;
            BST_SELDR: nxt_state = tms_s ? BST_SELIR : BST_CAPDR;
            BST_CAPDR: nxt_state = tms_s ? BST_EX1DR : BST_SHDR;
            BST_SHDR:  nxt_state = tms_s ? BST_EX1DR : BST_SHDR;
            BST_EX1DR: nxt_state = tms_s ? BST_UPDDR : BST_PSDR;
            BST_PSDR:  nxt_state = tms_s ? BST_EX2DR : BST_PSDR;
            BST_EX2DR: nxt_state = tms_s ? BST_UPDDR : BST_SHDR;
            BST_UPDDR: nxt_state = tms_s ? BST_SELDR : BST_RTI;
            BST_SELIR: nxt_state = tms_s ? BST_TLR   : BST_CAPIR;
            BST_CAPIR: nxt_state = tms_s ? BST_EX1IR : BST_SHIR;
            BST_SHIR:  nxt_state = tms_s ? BST_EX1IR : BST_SHIR;
            BST_EX1IR: nxt_state = tms_s ? BST_UPDIR : BST_PSIR;
            BST_PSIR:  nxt_state = tms_s ? BST_EX2IR : BST_PSIR;
            BST_EX2IR: nxt_state = tms_s ? BST_UPDIR : BST_SHIR;
            BST_UPDIR: nxt_state = tms_s ? BST_SELDR : BST_RTI;
            default:   nxt_state = BST_TLR;
        endcase
    end

    // state register; unreserved port keeps the controller parked in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= BST_TLR;
        end else if (!reserved_ff) begin
            state_ff <= BST_TLR;
        end else if (tck_rise) begin
            state_ff <= nxt_state;
        end
    end

    // register actions decoded from state
    wire in_tlr   = (state_ff == BST_TLR);
    wire cap_ir   = (state_ff == BST_CAPIR);
    wire sh_ir    = (state_ff == BST_SHIR);
    wire upd_ir   = (state_ff == BST_UPDIR);
    wire cap_dr   = (state_ff == BST_CAPDR);
    wire sh_dr    = (state_ff == BST_SHDR);
    wire upd_dr   = (state_ff == BST_UPDDR);

    // instruction register: shift stage and active instruction
    logic [BST_IR_W-1:0] ir_sh_ff;
    logic [BST_IR_W-1:0] ir_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_ff <= '0;
            ir_ff    <= BST_OP_IDCODE;
        end else if (in_tlr) begin
            ir_ff    <= BST_OP_IDCODE;
        end else if (tck_rise && cap_ir) begin
            ir_sh_ff <= BST_IR_CAPTURE;
        end else if (tck_rise && sh_ir) begin
            ir_sh_ff <= {tdi_s, ir_sh_ff[BST_IR_W-1:1]};
        end else if (tck_fall && upd_ir) begin
            ir_ff    <= ir_sh_ff;
        end
    end

    // instruction decode; any unused opcode falls back to bypass
    wire sel_extest = (ir_ff == BST_OP_EXTEST);
    wire sel_sample = (ir_ff == BST_OP_SAMPLE);
    wire sel_id     = (ir_ff == BST_OP_IDCODE);
    wire sel_bsr    = sel_extest | sel_sample;
    wire sel_byp    = ~(sel_bsr | sel_id);

    // identification word, lsb fixed at one
    wire [BST_ID_W-1:0] id_word = {BST_ID_VERSION, BST_ID_PART, BST_ID_NUMBER, BST_ID_LSB};

    // boundary capture vector: even cell is pin data, odd cell is enable
    logic [BST_BSR_W-1:0] bsr_cap;
    logic [BST_BSR_W-1:0] bsr_upd_ff;
    logic [BST_BSR_W-1:0] bsr_sh_ff;
    logic [BST_BSR_W-1:0] bsr_cap_sh;
    genvar gi;
    generate
        for (gi = 0; gi < BST_IO_N; gi++) begin : g_cell
            assign bsr_cap[2*gi]   = pad_sync_ff[gi];
            assign bsr_cap[2*gi+1] = core_oe[gi];
        end
    endgenerate
    assign bsr_cap_sh = {tdi_s, bsr_sh_ff[BST_BSR_W-1:1]};

    // data registers: capture, shift lsb first, update
    logic                byp_ff;
    logic [BST_ID_W-1:0] id_sh_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byp_ff     <= 1'b0;
            id_sh_ff   <= '0;
            bsr_sh_ff  <= '0;
        end else if (tck_rise && cap_dr) begin
            byp_ff     <= 1'b0;
            id_sh_ff   <= id_word;
            if (sel_bsr) begin
                bsr_sh_ff <= bsr_cap;
            end
        end else if (tck_rise && sh_dr) begin
            byp_ff     <= tdi_s;
            id_sh_ff   <= {tdi_s, id_sh_ff[BST_ID_W-1:1]};
            if (sel_bsr) begin
                bsr_sh_ff <= bsr_cap_sh;
            end
        end
    end

    // update latch of the boundary cells; cleared in reset state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bsr_upd_ff <= '0;
        end else if (in_tlr) begin
            bsr_upd_ff <= '0;
        end else if (tck_fall && upd_dr && sel_bsr) begin
            bsr_upd_ff <= bsr_sh_ff;
        end
    end

    // serial output source, instruction path has priority in ir shift
    wire dr_lsb  = sel_bsr ? bsr_sh_ff[0] : (sel_id ? id_sh_ff[0] : byp_ff);
    wire tdo_src = sh_ir ? ir_sh_ff[0] : dr_lsb;
    wire tdo_en  = reserved_ff & (sh_ir | sh_dr);

    // tdo moves on falling tck so the tester samples it on the rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_o  <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_o  <= tdo_src;
            tdo_oe <= tdo_en;
        end else if (!reserved_ff) begin
            tdo_oe <= 1'b0;
        end
    end

    // pad steering: extest hands the pins to the boundary cells
    logic [BST_IO_N-1:0] nxt_pad_out;
    logic [BST_IO_N-1:0] nxt_pad_oe;
    wire  drive_bsr = reserved_ff & sel_extest;
    generate
        for (gi = 0; gi < BST_IO_N; gi++) begin : g_pad
            assign nxt_pad_out[gi] = drive_bsr ? bsr_upd_ff[2*gi]   : core_out[gi];
            assign nxt_pad_oe[gi]  = drive_bsr ? bsr_upd_ff[2*gi+1] : core_oe[gi];
        end
    endgenerate

    // registered pad and core-side outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out   <= '0;
            pad_oe    <= '0;
            core_in   <= '0;
            user_mode <= 1'b1;
        end else begin
            pad_out   <= nxt_pad_out;
            pad_oe    <= nxt_pad_oe;
            core_in   <= pad_sync_ff;
            user_mode <= ~reserved_ff;
        end
    end

endmodule : bst_tap

// ---- dv/bst_tap_props.sv ----
// port assertions for the boundary-scan tap
`timescale 1ns/1ps
module bst_tap_props
    import bst_pkg::*;
(
    input wire logic                clk,
    input wire logic                reset_n,
    input wire bst_pins_s           pins,
    input wire logic [BST_IO_N-1:0] pad_in,
    input wire logic [BST_IO_N-1:0] core_out,
    input wire logic [BST_IO_N-1:0] core_oe,
    input wire logic                tdo_o,
    input wire logic                tdo_oe,
    input wire logic [BST_IO_N-1:0] pad_out,
    input wire logic [BST_IO_N-1:0] pad_oe,
    input wire logic [BST_IO_N-1:0] core_in,
    input wire logic                user_mode
);
    logic       tck_ff;
    logic       rst_held_ff; // reset already seen by a clock edge, outputs known from then on
    logic [2:0] ones_ff;
    logic [2:0] nxt_ones;
    wire        tck_rise = pins.tck && !tck_ff;
    // consecutive tck rises with tms high, saturating at five
    assign nxt_ones = !tck_rise ? ones_ff : !pins.tms ? 3'h0 : (ones_ff == 3'h5) ? 3'h5 : ones_ff + 3'h1;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tck_ff      <= 1'b0;
            rst_held_ff <= 1'b1;
            ones_ff     <= 3'h0;
        end else begin
            tck_ff      <= pins.tck;
            rst_held_ff <= 1'b0;
            ones_ff     <= nxt_ones;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    tdo_on_fall_a: assert property ($changed(tdo_o) |-> !$past(pins.tck, 2))
        else $error("tdo moved away from a tck fall");
    oe_on_fall_a: assert property ($changed(tdo_oe) |-> !$past(pins.tck, 2))
        else $error("tdo enable moved away from a tck fall");
    oe_needs_port_a: assert property (tdo_oe |-> !user_mode)
        else $error("tdo driven while pins are user i/o");
    user_pads_a: assert property (user_mode && $past(reset_n, 3) |-> pad_out == $past(core_out) && pad_oe == $past(core_oe))
        else $error("user pads not following core");
    core_in_a: assert property ((reset_n && $stable(pad_in))[*7] |-> core_in == pad_in)
        else $error("core input not following pad");
    reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
        rst_held_ff && !reset_n |-> !tdo_o && !tdo_oe && pad_oe == 8'h00 && user_mode)
        else $error("outputs active in reset");
    tms_reset_a: assert property (ones_ff == 3'h5 && !pins.tck |-> !tdo_oe)
        else $error("tdo enabled after five tms highs");
    tlr_pads_a: assert property (ones_ff == 3'h5 && !pins.tck |-> pad_out == $past(core_out))
        else $error("pads held by cells after five tms highs");
endmodule : bst_tap_props

bind bst_tap bst_tap_props u_props (.clk(clk), .reset_n(reset_n), .pins(pins), .pad_in(pad_in),
    .core_out(core_out), .core_oe(core_oe), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .pad_out(pad_out),
    .pad_oe(pad_oe), .core_in(core_in), .user_mode(user_mode));

// ---- dv/bst_tester.sv ----
// external test controller model on the serial test port
`timescale 1ns/1ps
module bst_tester (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // tck rests low between frames; tms idles high like its pull-up
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one tck period; tdo taken just before the rise that shifts it
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #80;
        q = tdo;
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask : step
    // run-test/idle through one ir or dr scan and back, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        step(1'b1, 1'b1, q);
        if (ir) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask : scan
endmodule : bst_tester

// ---- dv/test_boundary_scan_tap.sv ----
// self-checking bench for the boundary-scan tap
`timescale 1ns/1ps
module test_boundary_scan_tap import bst_pkg::*;;
    localparam logic [31:0] ID_EXP = {BST_ID_VERSION, BST_ID_PART, BST_ID_NUMBER, BST_ID_LSB};
    logic                clk = 1'b0;
    logic                reset_n = 1'b0;
    logic                reserve = 1'b1;
    logic [BST_IO_N-1:0] pad_in = 8'h00;
    logic [BST_IO_N-1:0] core_out = 8'h00;
    logic [BST_IO_N-1:0] core_oe = 8'h00;
    logic                tck, tms, tdi, tdo_o, tdo_oe, user_mode;
    logic [BST_IO_N-1:0] pad_out, pad_oe, core_in;
    bst_pins_s           pins;
    int                  failures = 0;
    int                  n_checks = 0;
    int                  cycles = 0;
    assign pins = {reserve, tck, tms, tdi};
    bst_tap u_dut (.clk(clk), .reset_n(reset_n), .pins(pins), .pad_in(pad_in), .core_out(core_out),
        .core_oe(core_oe), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .pad_out(pad_out), .pad_oe(pad_oe),
        .core_in(core_in), .user_mode(user_mode));
    // undriven tdo shows the inverse, never a stale bit
    bst_tester u_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo_o : ~tdo_o));
    always #4 clk = ~clk;
    // watchdog against a hung test run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic do_reset(input logic res);
        @(negedge clk);
        reserve = res;
        reset_n = 1'b0;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (12) @(negedge clk);
    endtask : do_reset
    task automatic t_idcode();
        logic q;
        logic [31:0] d;
        check("user_mode", user_mode, 1'b0);
        u_tst.step(1'b0, 1'b1, q);
        u_tst.scan(1'b0, 32, 32'h0, d);
        check("idcode at power-up", d, ID_EXP);
        u_tst.scan(1'b1, 3, {29'h0, BST_OP_IDCODE}, d);
        check("ir capture", d[2:0], BST_IR_CAPTURE);
        u_tst.scan(1'b0, 32, 32'hFFFF_FFFF, d);
        check("idcode", d, ID_EXP);
    endtask : t_idcode
    task automatic t_bypass();
        logic [31:0] d;
        logic [2:0] ops [2] = '{BST_OP_BYPASS, 3'h3};
        foreach (ops[k]) begin
            u_tst.scan(1'b1, 3, {29'h0, ops[k]}, d);
            u_tst.scan(1'b0, 8, 32'h0000_00B4, d);
            check("bypass path", d[7:0], 8'h68);
        end
    endtask : t_bypass
    task automatic t_boundary();
        logic [31:0] d;
        logic [15:0] cap;
        logic [7:0]  ed, en;
        @(negedge clk);
        pad_in = 8'hA5;
        core_oe = 8'h3C;
        core_out = 8'h0F;
        for (int i = 0; i < BST_IO_N; i++) cap[2*i +: 2] = {core_oe[i], pad_in[i]};
        u_tst.scan(1'b1, 3, {29'h0, BST_OP_SAMPLE}, d);
        u_tst.scan(1'b0, 16, 32'h0000_9C63, d);
        check("sample capture", d[15:0], cap);
        check("pads in sample", pad_out, core_out);
        check("core_in", core_in, pad_in);
        u_tst.scan(1'b1, 3, {29'h0, BST_OP_EXTEST}, d);
        for (int i = 0; i < BST_IO_N; i++) {en[i], ed[i]} = 2'(16'h9C63 >> (2 * i));
        check("extest data", pad_out, ed);
        check("extest enable", pad_oe, en);
    endtask : t_boundary
    task automatic t_tms_reset();
        logic q;
        logic [31:0] d;
        u_tst.step(1'b1, 1'b1, q);
        u_tst.step(1'b0, 1'b1, q);
        u_tst.step(1'b0, 1'b1, q);
        repeat (5) u_tst.step(1'b1, 1'b1, q);
        check("pads after tms reset", pad_oe, core_oe);
        u_tst.step(1'b0, 1'b1, q);
        u_tst.scan(1'b0, 32, 32'h0, d);
        check("idcode after tms reset", d, ID_EXP);
    endtask : t_tms_reset
    task automatic t_unreserved();
        logic [31:0] d;
        do_reset(1'b0);
        u_tst.scan(1'b0, 32, 32'h0, d);
        check("user mode", user_mode, 1'b1);
        check("user pads", pad_out, core_out);
    endtask : t_unreserved
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        do_reset(1'b1);
        t_idcode();
        t_bypass();
        t_boundary();
        t_tms_reset();
        t_unreserved();
        stop_test();
    end
endmodule : test_boundary_scan_tap
